// ==== rtl/issue_grouping_fetch_stall.sv ====
// Purpose: Decode issue grouping and instruction buffer fetch stall control
// Assumes: Slot flags are pre-decoded by the buffer; slot 0 is oldest
// Notes: APB slave, zero wait states; unmapped addresses return pslverr
// Function
// [RULE1] At most three issue per cycle, one per pipeline.
// [RULE2] Primary opcode 0b0100xx goes to the branch pipeline.
// [RULE3] Third slot holds only a PC-relative branch.
// [RULE4] Never mix float and integer operations in a group.
// [RULE5] Load/store with update also takes the ALU pipeline.
// [RULE6] No issue while stalled with a blocked A stage instruction.
// [RULE7] Stop on empty buffer, three placed, or two plus non-PC-relative.
// [RULE8] Stop on pipeline reuse or duplicate destination register.
// [RULE9] Serialising instructions issue alone.
// [RULE10] Link/count/exception SPR moves are ALU; other SPR moves alone.
// [RULE11] No conditional branch after a move-to-SPR in the group.
// [RULE12] Float divide, record bit, status ops only start a group.
// [RULE13] Indexed string access waits for empty integer pipeline.
// [RULE14] Single issue under trace or single-issue mode; fault ends group.
// [RULE15] Multi-flow instructions block issue one cycle per extra flow.
// [RULE16] One instruction issues after an invalid finder mispredict.
// [RULE17] No buffer load while fetch-buffer portion holds instructions.
// [RULE18] Main TLB hit costs four cycles; full miss raises interrupt on issue.
// [RULE19] Cache miss stalls four cycles, five without speculative success.
// [RULE20] Stale indirect target stalls until buffer small and modifiers done.
// [RULE21] Context events hold fetch until store queue is clear.
// [RULE22] Four-entry branch queue; entries free on issue, reuse next cycle.
// [RULE23] Grouping is combinational on pre-decoded flags each cycle.
`timescale 1ns/10ps
module issue_grouping_fetch_stall (
	input wire logic clk, // Core clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_valid, // Buffer entry valid
	input wire logic [issue_grouping_pkg::SLOTS-1:0][5:0] slot_opcode, // Primary opcode
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_mem, // Memory access
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_pcrel_branch, // PC-relative branch
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_cond_branch, // Conditional branch
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_float, // Float operation
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_int, // Integer operation
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_ls_update, // Load/store with update
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_serial, // Serialising class
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_spr_move, // Any SPR move
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_spr_alu, // SPR is link/count/exception
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_mtspr, // Move to SPR
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_fp_start, // Float start-only class
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_string_idx, // Indexed string access
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_fetch_fault, // Storage/TLB/break fault
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_tlb_fault, // Full TLB miss address
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_ctx_sync, // Instr sync or int return
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_queue_entry, // Holds branch queue slot
	input wire logic [issue_grouping_pkg::SLOTS-1:0] slot_wr_en, // Writes a register
	input wire logic [issue_grouping_pkg::SLOTS-1:0][4:0] slot_wr_reg, // Destination register
	input wire logic [issue_grouping_pkg::SLOTS-1:0][4:0] slot_flows, // Flow count
	input wire logic pipe_stalled, // Pipeline stalled
	input wire logic a_stage_blocked, // Valid A stage instruction cannot advance
	input wire logic int_pipe_busy, // Integer pipeline holds instructions
	input wire logic finder_mispredict, // Invalid finder entry mispredict pulse
	input wire logic fetch_buf_nonempty, // Fetch-buffer portion not empty
	input wire logic instruction_translation_buffer_miss, // Current fetch misses translation buffer
	input wire logic main_tlb_hit, // Main TLB satisfies the miss
	input wire logic icache_miss, // Current fetch misses instruction cache
	input wire logic l2_spec_ok, // Second-level speculative access succeeded
	input wire logic miss_resolved, // Translation or refill complete
	input wire logic indirect_taken, // Indirect branch in buffer predicted taken
	input wire logic indirect_stale, // Its target register is not current
	input wire logic modifiers_pending, // Modifiers of that register outstanding
	input wire logic [3:0] buf_count, // Instructions in buffer
	input wire logic second_level_cache_control_write, // Second-level cache control written
	input wire logic interrupt_taken, // Interrupt taken pulse
	input wire logic sq_ctx_clear, // Store queue holds no cache/sync/diag ops
	input wire logic [1:0] fetch_need_entries, // Queue entries the next load needs
	output logic [issue_grouping_pkg::SLOTS-1:0] issue_valid, // Per-slot issue
	output logic [issue_grouping_pkg::SLOTS-1:0][1:0] issue_pipe, // Per-slot pipeline
	output logic fetch_load_en, // Buffer may load this cycle
	output logic tlb_miss_irq, // TLB miss interrupt pulse
	output logic flow_active // Extra flows in progress
);
	import issue_grouping_pkg::*;

	logic [2:0] ctrl_q;
	logic [31:0] issued_q;
	logic single_q;
	logic ctx_wait_q;
	logic [4:0] flow_q;
	logic [2:0] qcnt_q;
	logic [2:0] miss_cnt_q;
	logic [1:0] group_q;
	fetch_state_t fstate_q;
	fetch_state_t fstate_d;
	logic [2:0] pipe_used;
	logic [NREGS-1:0] wr_mask;
	logic has_fp;
	logic has_int;
	logic has_mtspr;
	logic has_alone;
	logic has_fault;
	logic stop;
	logic ok;
	logic [2:0] need;
	logic single_mode;
	logic hold;
	logic [1:0] group_size;
	logic [2:0] freed;
	logic ind_stall;
	logic queue_ok;
	logic apb_wr;
	logic ctx_set;

	// Trace, single-issue mode and the finder recovery cycle all cap the group at one
	assign single_mode = ctrl_q[CTRL_SI_BIT] | ctrl_q[CTRL_BT_BIT] | ctrl_q[CTRL_ST_BIT] | single_q;

	// Blocked A stage or pending extra flows freeze every slot, not just the oldest
	assign hold = (pipe_stalled & a_stage_blocked) | (flow_q != 5'h0); // [RULE6] [RULE15]

	// Pipeline classification per slot
	// Link/count/exception SPR moves stay on the ALU even when flagged as memory
	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : g_class
			always_comb begin
				if (slot_opcode[g][5:2] == BR_OPCODE_PREFIX) begin
					issue_pipe[g] = PIPE_BR; // [RULE2]
				end else if (slot_mem[g] & ~slot_spr_alu[g]) begin
					issue_pipe[g] = PIPE_LS;
				end else begin
					issue_pipe[g] = PIPE_ALU; // [RULE10]
				end
			end
		end
	endgenerate

	// Group formation, oldest slot first
	always_comb begin // [RULE23]
		pipe_used = 3'h0;
		wr_mask = '0;
		has_fp = 1'b0;
		has_int = 1'b0;
		has_mtspr = 1'b0;
		has_alone = 1'b0;
		has_fault = 1'b0;
		stop = hold;
		issue_valid = '0;
		for (int i = 0; i < SLOTS; i++) begin
			need = 3'h1 << issue_pipe[i];
			if (slot_ls_update[i]) begin
				need = need | (3'h1 << PIPE_ALU); // [RULE5]
			end
			ok = ~stop & slot_valid[i]; // [RULE7]
			// Last slot is only reached once both older slots have been placed
			if (i == LAST_SLOT && !slot_pcrel_branch[i]) begin
				ok = 1'b0; // [RULE3] [RULE7]
			end
			if ((pipe_used & need) != 3'h0) begin
				ok = 1'b0; // [RULE1] [RULE8]
			end
			if (slot_wr_en[i] && wr_mask[slot_wr_reg[i]]) begin
				ok = 1'b0; // [RULE8]
			end
			if ((slot_float[i] && has_int) || (slot_int[i] && has_fp)) begin
				ok = 1'b0; // [RULE4]
			end
			if (i > 0 && (slot_serial[i] || has_alone)) begin
				ok = 1'b0; // [RULE9]
			end
			if (i > 0 && slot_spr_move[i] && !slot_spr_alu[i]) begin
				ok = 1'b0; // [RULE10]
			end
			if (has_mtspr && slot_cond_branch[i]) begin
				ok = 1'b0; // [RULE11]
			end
			if (i > 0 && slot_fp_start[i]) begin
				ok = 1'b0; // [RULE12]
			end
			if (slot_string_idx[i] && int_pipe_busy) begin
				ok = 1'b0; // [RULE13]
			end
			if (i > 0 && (single_mode || has_fault)) begin
				ok = 1'b0; // [RULE14] [RULE16]
			end
			if (ok) begin
				issue_valid[i] = 1'b1;
				pipe_used = pipe_used | need;
				if (slot_wr_en[i]) begin
					wr_mask[slot_wr_reg[i]] = 1'b1;
				end
				has_fp = has_fp | slot_float[i];
				has_int = has_int | slot_int[i];
				has_mtspr = has_mtspr | slot_mtspr[i];
				has_alone = has_alone | slot_serial[i]
					| (slot_spr_move[i] & ~slot_spr_alu[i]);
				// A full translation miss is a fetch interrupt too, so it ends the group
				has_fault = has_fault | slot_fetch_fault[i] | slot_tlb_fault[i]; // [RULE14]
			end else begin
				stop = 1'b1;
			end
		end
	end

	// Group size feeds the status view and the running issue total
	always_comb begin
		group_size = 2'h0;
		freed = 3'h0;
		for (int i = 0; i < SLOTS; i++) begin
			group_size = group_size + {1'b0, issue_valid[i]};
			freed = freed + {2'h0, issue_valid[i] & slot_queue_entry[i]}; // [RULE22]
		end
	end

	// Mispredict on a stale finder entry limits the next cycle to one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			single_q <= 1'b0;
		end else begin
			single_q <= finder_mispredict; // [RULE16]
		end
	end

	// Extra decode cycles of a multi-flow instruction in slot 0
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flow_q <= 5'h0;
		end else if (flow_q != 5'h0) begin
			if (!(pipe_stalled & a_stage_blocked)) begin
				flow_q <= flow_q - 5'h1; // [RULE15]
			end
		end else if (issue_valid[0] && slot_flows[0] > 5'h1) begin
			flow_q <= slot_flows[0] - 5'h1; // [RULE15]
		end
	end

	// Interrupt raised when a full-miss address actually issues
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tlb_miss_irq <= 1'b0;
		end else begin
			tlb_miss_irq <= |(issue_valid & slot_tlb_fault); // [RULE18]
		end
	end

	// Fetch miss penalty: the miss cycle counts as the first stall cycle
	always_comb begin
		fstate_d = fstate_q;
		case (fstate_q)
			F_RUN: begin
				if ((instruction_translation_buffer_miss && main_tlb_hit) || icache_miss) begin
					fstate_d = F_MISS;
				end
			end
			F_MISS: begin
				if (miss_cnt_q <= 3'h1 && miss_resolved) begin
					fstate_d = F_RUN;
				end
			end
			default: begin
				fstate_d = F_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fstate_q <= F_RUN;
		end else begin
			fstate_q <= fstate_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			miss_cnt_q <= 3'h0;
		end else if (fstate_q == F_RUN) begin
			if (instruction_translation_buffer_miss && main_tlb_hit) begin
				miss_cnt_q <= INSTRUCTION_TRANSLATION_BUFFER_MAIN_HIT_CYC - 3'h1; // [RULE18]
			end else if (icache_miss && l2_spec_ok) begin
				miss_cnt_q <= ICACHE_SPEC_OK_CYC - 3'h1; // [RULE19]
			end else if (icache_miss) begin
				miss_cnt_q <= ICACHE_SPEC_FAIL_CYC - 3'h1; // [RULE19]
			end
		end else if (miss_cnt_q != 3'h0) begin
			miss_cnt_q <= miss_cnt_q - 3'h1;
		end
	end

	// Context sync wait; a new event wins over the clear
	assign ctx_set = (|(issue_valid & slot_ctx_sync)) | second_level_cache_control_write | interrupt_taken;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctx_wait_q <= 1'b0;
		end else if (ctx_set) begin
			ctx_wait_q <= 1'b1; // [RULE21]
		end else if (sq_ctx_clear) begin
			ctx_wait_q <= 1'b0; // [RULE21]
		end
	end

	// Held until the buffer drains to the limit and every modifier has retired
	assign ind_stall = indirect_taken & indirect_stale
		& ((buf_count > IND_BUF_LIMIT) | modifiers_pending); // [RULE20]

	// Room is judged on the registered count, so freed entries serve next cycle
	assign queue_ok = ({1'b0, fetch_need_entries} <= (QUEUE_DEPTH - qcnt_q)); // [RULE22]

	// A miss input blocks its own cycle; the miss state covers the cycles after a main TLB hit or cache miss
	assign fetch_load_en = (fstate_q == F_RUN) & ~instruction_translation_buffer_miss & ~icache_miss
		& ~fetch_buf_nonempty & ~ctx_wait_q & ~ind_stall & queue_ok; // [RULE17] [RULE19]


	// No saturation: a load never takes more room than queue_ok has granted
	always_ff @(posedge clk) begin
		if (!rstn) begin
			qcnt_q <= 3'h0;
		end else if (fetch_load_en) begin
			qcnt_q <= qcnt_q + {1'b0, fetch_need_entries} - freed; // [RULE22]
		end else begin
			qcnt_q <= qcnt_q - freed; // [RULE22]
		end
	end

	assign flow_active = (flow_q != 5'h0);

	// APB slave, always ready
	assign pready = 1'b1;
	assign apb_wr = psel & penable & pwrite;


	// Only the three mode bits are kept; other written bits are dropped
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
		end else if (apb_wr && paddr == CTRL_OFS) begin
			ctrl_q <= pwdata[2:0]; // [RULE14]
		end
	end

	// Issue count write is ignored; it is a running total
	always_ff @(posedge clk) begin
		if (!rstn) begin
			issued_q <= 32'h0;
			group_q <= 2'h0;
		end else begin
			issued_q <= issued_q + {30'h0, group_size};
			group_q <= group_size;
		end
	end


	// Read mux is combinational so the single access cycle needs no wait state
	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		case (paddr)
			CTRL_OFS: begin
				prdata[2:0] = ctrl_q;
			end
			STATUS_OFS: begin
				prdata[ST_QCNT_LSB +: 3] = qcnt_q;
				prdata[ST_FETCH_EN_BIT] = fetch_load_en;
				prdata[ST_CTX_WAIT_BIT] = ctx_wait_q;
				prdata[ST_FLOW_BIT] = flow_active;
				prdata[ST_MISS_BIT] = (fstate_q == F_MISS);
				prdata[ST_GROUP_LSB +: 2] = group_q;
			end
			ISSUED_OFS: begin
				prdata = issued_q;
			end
			default: begin
				pslverr = psel & penable;
			end
		endcase
	end
endmodule // issue_grouping_fetch_stall

// ==== rtl/issue_grouping_pkg.sv ====
// Purpose: Shared constants and types for issue grouping and fetch stall control
// Assumes: One core clock, APB register access with 32-bit data
// Notes: Penalties are in core clock cycles
package issue_grouping_pkg;
	localparam int SLOTS = 3;
	localparam int QDEPTH = 4;
	localparam int NREGS = 32;

	// Pipeline codes
	localparam logic [1:0] PIPE_ALU = 2'h0;
	localparam logic [1:0] PIPE_LS = 2'h1;
	localparam logic [1:0] PIPE_BR = 2'h2;

	// Primary opcode 0b0100xx selects the branch pipeline
	localparam logic [3:0] BR_OPCODE_PREFIX = 4'h4;

	// Slot that only a PC-relative branch may fill
	localparam int LAST_SLOT = 2;

	// Fetch penalties in cycles, indirect-branch buffer limit and branch queue depth
	localparam logic [2:0] INSTRUCTION_TRANSLATION_BUFFER_MAIN_HIT_CYC = 3'h4;
	localparam logic [2:0] ICACHE_SPEC_OK_CYC = 3'h4;
	localparam logic [2:0] ICACHE_SPEC_FAIL_CYC = 3'h5;
	localparam logic [3:0] IND_BUF_LIMIT = 4'h3;
	localparam logic [2:0] QUEUE_DEPTH = 3'h4;

	// APB register map
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] ISSUED_OFS = 12'h008;

	localparam int CTRL_SI_BIT = 0;
	localparam int CTRL_BT_BIT = 1;
	localparam int CTRL_ST_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	localparam int ST_QCNT_LSB = 0;
	localparam int ST_FETCH_EN_BIT = 3;
	localparam int ST_CTX_WAIT_BIT = 4;
	localparam int ST_FLOW_BIT = 5;
	localparam int ST_MISS_BIT = 6;
	localparam int ST_GROUP_LSB = 8;

	typedef enum logic [1:0] {
		F_RUN = 2'b01,
		F_MISS = 2'b10
	} fetch_state_t;
endpackage

// ==== verification/far_side_model.sv ====
// Purpose: Far-side model of miss refill and store queue drain
// Assumes: Misses and context events are one-cycle levels from the bench
// Notes: Slow mode stretches the refill so longer stalls are exercised
`timescale 1ns/10ps
module far_side_model (
	input wire logic clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire logic slow, // Slow refill select
	input wire logic miss_start, // Fetch miss this cycle
	input wire logic ctx_event, // Context event this cycle
	output logic miss_resolved, // Refill complete
	output logic sq_ctx_clear // Store queue clean
);
	logic [7:0] refill_q;
	logic [2:0] drain_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			refill_q <= 8'hff;
		end else if (miss_start) begin
			refill_q <= 8'h00;
		end else if (refill_q != 8'hff) begin
			refill_q <= refill_q + 8'h01;
		end
	end
	// Queue drains four cycles after each event
	always_ff @(posedge clk) begin
		if (!rstn) begin
			drain_q <= 3'h0;
		end else if (ctx_event) begin
			drain_q <= 3'h4;
		end else if (drain_q != 3'h0) begin
			drain_q <= drain_q - 3'h1;
		end
	end
	assign miss_resolved = refill_q >= (slow ? 8'h0a : 8'h00);
	assign sq_ctx_clear = drain_q == 3'h0;
endmodule // far_side_model

// ==== verification/issue_grouping_fetch_stall_chk.sv ====
// Purpose: Port-level assertions for issue grouping and fetch stall
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/10ps
module issue_grouping_chk (
	input wire logic clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire logic [2:0][5:0] slot_opcode, // Opcodes
	input wire logic [2:0] slot_pcrel_branch, // PC-relative
	input wire logic [2:0] slot_float, // Float
	input wire logic [2:0] slot_int, // Integer
	input wire logic [2:0] slot_serial, // Serialising
	input wire logic [2:0] slot_tlb_fault, // TLB fault
	input wire logic [2:0][4:0] slot_flows, // Flows
	input wire logic pipe_stalled, // Stalled
	input wire logic a_stage_blocked, // A blocked
	input wire logic finder_mispredict, // Finder pulse
	input wire logic fetch_buf_nonempty, // Fetch buffer busy
	input wire logic icache_miss, // Cache miss
	input wire logic l2_spec_ok, // Speculative ok
	input wire logic indirect_taken, // Indirect taken
	input wire logic indirect_stale, // Stale target
	input wire logic modifiers_pending, // Modifiers out
	input wire logic [2:0] issue_valid, // Issue
	input wire logic [2:0][1:0] issue_pipe, // Pipes
	input wire logic fetch_load_en, // Load enable
	input wire logic tlb_miss_irq // TLB interrupt
);
	import issue_grouping_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_stall_no_issue: assert property (
		pipe_stalled && a_stage_blocked |-> issue_valid == 3'h0) else $error("issue while stalled");
	chk_third_slot_pcrel: assert property (
		issue_valid[2] |-> slot_pcrel_branch[2]) else $error("third slot not pc-relative");
	chk_branch_pipe: assert property (
		issue_valid[0] && slot_opcode[0][5:2] == BR_OPCODE_PREFIX |-> issue_pipe[0] == PIPE_BR)
		else $error("branch opcode not on branch pipe");
	chk_pipe_unique: assert property (
		issue_valid[1] |-> issue_valid[0] && issue_pipe[0] != issue_pipe[1])
		else $error("pipe used twice");
	chk_no_float_int: assert property (
		issue_valid[1] |-> !(slot_float[0] && slot_int[1] || slot_int[0] && slot_float[1]))
		else $error("float and integer grouped");
	chk_serial_alone: assert property (
		issue_valid[1] |-> slot_serial[1:0] == 2'h0) else $error("serial op grouped");
	chk_finder_single: assert property (
		$past(finder_mispredict) |-> !issue_valid[1]) else $error("group after finder miss");
	chk_fetch_buf_hold: assert property (
		fetch_buf_nonempty |-> !fetch_load_en) else $error("load with fetch buffer busy");
	chk_tlb_irq_cause: assert property (
		tlb_miss_irq |-> $past(issue_valid & slot_tlb_fault) != 3'h0) else $error("stray irq");
	chk_miss_five: assert property (
		$rose(icache_miss) && !l2_spec_ok && $past(fetch_load_en) |-> (!fetch_load_en) [*5])
		else $error("cache miss stall short");
	chk_flow_block: assert property (
		issue_valid[0] && slot_flows[0] == 5'h3 |=> (issue_valid == 3'h0) [*2])
		else $error("issue during extra flows");
	chk_indirect_hold: assert property (
		indirect_taken && indirect_stale && modifiers_pending |-> !fetch_load_en)
		else $error("load with stale indirect target");
endmodule // issue_grouping_chk
bind issue_grouping_fetch_stall issue_grouping_chk chk_i (.*);

// ==== verification/issue_grouping_fetch_stall_tb.sv ====
// Purpose: Self-checking bench for issue grouping and fetch stall control
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes: Issue and fetch outputs are judged at the falling edge
`timescale 1ns/10ps
module issue_grouping_fetch_stall_tb;
	import issue_grouping_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] slot_valid, slot_mem, slot_pcrel_branch, slot_cond_branch, slot_float, slot_int;
	logic [2:0] slot_ls_update, slot_serial, slot_spr_move, slot_spr_alu, slot_mtspr;
	logic [2:0] slot_fp_start, slot_string_idx, slot_fetch_fault, slot_tlb_fault, slot_ctx_sync;
	logic [2:0] slot_queue_entry, slot_wr_en, issue_valid;
	logic [2:0][5:0] slot_opcode;
	logic [2:0][4:0] slot_wr_reg, slot_flows;
	logic [2:0][1:0] issue_pipe;
	logic pipe_stalled, a_stage_blocked, int_pipe_busy, finder_mispredict, fetch_buf_nonempty;
	logic instruction_translation_buffer_miss, main_tlb_hit, icache_miss, l2_spec_ok, miss_resolved, indirect_taken;
	logic indirect_stale, modifiers_pending, second_level_cache_control_write, interrupt_taken, sq_ctx_clear;
	logic fetch_load_en, tlb_miss_irq, flow_active;
	logic [3:0] buf_count;
	logic [1:0] fetch_need_entries;
	int err_count, checked;
	issue_grouping_fetch_stall dut (.*);
	far_side_model partner (.clk, .rstn, .slow, .miss_start(icache_miss | instruction_translation_buffer_miss),
		.ctx_event(second_level_cache_control_write | interrupt_taken | (|(issue_valid & slot_ctx_sync))),
		.miss_resolved, .sq_ctx_clear);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic timeout;
		err_count++;
		complete_run;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, ee);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) timeout;
		if (!w) chk(prdata, d);
		chk(pslverr, ee);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Baseline group: ALU op, load, PC-relative branch
	task automatic pre;
		@(posedge clk);
		slot_valid <= 3'h7;
		slot_mem <= 3'h2;
		slot_pcrel_branch <= 3'h4;
		slot_int <= 3'h1;
		slot_wr_en <= 3'h3;
		slot_opcode <= {6'h12, 6'h20, 6'h0e};
		slot_wr_reg <= {5'h0, 5'h2, 5'h1};
		slot_flows <= {5'h1, 5'h1, 5'h1};
		{slot_cond_branch, slot_float, slot_ls_update, slot_serial, slot_spr_move, slot_spr_alu,
			slot_mtspr, slot_fp_start, slot_string_idx, slot_fetch_fault, slot_tlb_fault,
			slot_ctx_sync, slot_queue_entry, pipe_stalled, a_stage_blocked, int_pipe_busy,
			finder_mispredict, fetch_buf_nonempty, instruction_translation_buffer_miss, main_tlb_hit, icache_miss,
			l2_spec_ok, indirect_taken, indirect_stale, modifiers_pending, buf_count,
			second_level_cache_control_write, interrupt_taken, fetch_need_entries, slow} <= '0;
	endtask
	task automatic look(input logic [2:0] e);
		@(negedge clk);
		chk(issue_valid, e);
	endtask
	task automatic en_is(input logic e);
		@(negedge clk);
		chk(fetch_load_en, e);
	endtask
	task automatic cnt_low(input int exp);
		int i, n;
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (fetch_load_en === 1'b1) break;
			n++;
			@(posedge clk);
			icache_miss <= 1'b0;
			instruction_translation_buffer_miss <= 1'b0;
		end
		if (i == 40) timeout;
		chk(n, exp);
	endtask
	task automatic t_apb;
		apb(1'b0, CTRL_OFS, 32'h0, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h5, 1'b0);
		apb(1'b0, CTRL_OFS, 32'h5, 1'b0);
		apb(1'b1, 12'h00c, 32'h7, 1'b1);
		apb(1'b0, 12'h00c, 32'h0, 1'b1);
		apb(1'b1, CTRL_OFS, 32'h0, 1'b0);
	endtask
	task automatic t_group;
		pre;
		look(3'h7);
		chk(issue_pipe, {PIPE_BR, PIPE_LS, PIPE_ALU});
		pre;
		slot_pcrel_branch <= 3'h0;
		look(3'h3);
		pre;
		slot_opcode[0] <= 6'h13;
		look(3'h3);
		pre;
		slot_valid <= 3'h1;
		look(3'h1);
		pre;
		slot_mem <= 3'h0;
		look(3'h1);
		pre;
		slot_wr_reg[1] <= 5'h1;
		look(3'h1);
		pre;
		slot_serial <= 3'h1;
		look(3'h1);
		pre;
		slot_float <= 3'h2;
		look(3'h1);
		pre;
		slot_ls_update <= 3'h2;
		look(3'h1);
		pre;
		slot_spr_move <= 3'h1;
		look(3'h1);
		pre;
		{slot_spr_move, slot_spr_alu, slot_mtspr, slot_cond_branch} <= {9'h049, 3'h4};
		look(3'h3);
		pre;
		slot_fp_start <= 3'h2;
		look(3'h1);
		pre;
		{slot_string_idx, int_pipe_busy} <= 4'h3;
		look(3'h0);
		pre;
		{pipe_stalled, a_stage_blocked} <= 2'h3;
		look(3'h0);
		pre;
		slot_fetch_fault <= 3'h1;
		look(3'h1);
	endtask
	task automatic t_modes;
		int b;
		for (b = 0; b < 3; b++) begin
			apb(1'b1, CTRL_OFS, 32'h1 << b, 1'b0);
			pre;
			look(3'h1);
		end
		apb(1'b1, CTRL_OFS, 32'h0, 1'b0);
		pre;
		finder_mispredict <= 1'b1;
		@(posedge clk);
		finder_mispredict <= 1'b0;
		look(3'h1);
		look(3'h7);
	endtask
	// Multi-flow ops belong to the serialising class, so they issue alone
	task automatic t_flow;
		pre;
		slot_flows[0] <= 5'h3;
		slot_serial[0] <= 1'b1;
		look(3'h1);
		@(posedge clk);
		slot_flows[0] <= 5'h1;
		slot_serial[0] <= 1'b0;
		look(3'h0);
		chk(flow_active, 1'b1);
		look(3'h0);
		look(3'h7);
		pre;
		slot_flows[0] <= 5'h0;
		look(3'h7);
		look(3'h7);
		pre;
		slot_tlb_fault <= 3'h1;
		look(3'h1);
		pre;
		@(negedge clk);
		chk(tlb_miss_irq, 1'b1);
	endtask
	task automatic t_fetch;
		pre;
		fetch_buf_nonempty <= 1'b1;
		en_is(1'b0);
		pre;
		{indirect_taken, indirect_stale, buf_count} <= 6'h34;
		en_is(1'b0);
		@(posedge clk);
		buf_count <= 4'h3;
		en_is(1'b1);
		@(posedge clk);
		modifiers_pending <= 1'b1;
		en_is(1'b0);
	endtask
	task automatic miss(input logic ic, sp, hit, sl, input int exp);
		pre;
		icache_miss <= ic;
		instruction_translation_buffer_miss <= !ic;
		main_tlb_hit <= hit;
		l2_spec_ok <= sp;
		slow <= sl;
		cnt_low(exp);
	endtask
	task automatic t_ctx;
		int e;
		for (e = 0; e < 3; e++) begin
			pre;
			case (e)
				0: second_level_cache_control_write <= 1'b1;
				1: interrupt_taken <= 1'b1;
				default: slot_ctx_sync <= 3'h1;
			endcase
			pre;
			cnt_low(5);
		end
	endtask
	task automatic t_queue;
		pre;
		fetch_need_entries <= 2'h2;
		en_is(1'b1);
		en_is(1'b1);
		en_is(1'b0);
		@(posedge clk);
		fetch_need_entries <= 2'h1;
		slot_queue_entry <= 3'h1;
		en_is(1'b0);
		@(posedge clk);
		slot_queue_entry <= 3'h0;
		en_is(1'b1);
		en_is(1'b0);
		pre;
		apb(1'b0, STATUS_OFS, 32'h30c, 1'b0);
	endtask
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		checked = 0;
		pre;
		repeat (15) @(posedge clk);
		rstn <= 1'b1;
		t_apb;
		t_group;
		t_modes;
		t_flow;
		t_fetch;
		miss(1'b1, 1'b1, 1'b0, 1'b0, 4);
		miss(1'b1, 1'b0, 1'b0, 1'b0, 5);
		miss(1'b1, 1'b0, 1'b0, 1'b1, 12);
		miss(1'b0, 1'b0, 1'b1, 1'b0, 4);
		miss(1'b0, 1'b0, 1'b0, 1'b0, 1);
		t_ctx;
		t_queue;
		complete_run;
	end
endmodule // issue_grouping_fetch_stall_tb
